/* File: verilog/reset_pkg.sv */
// Package: constants and carrier types for the system reset block
package reset_pkg;
    // ------------------------------------------------------------
    // Widths and timing
    // ------------------------------------------------------------
    localparam int BOOT_WIDTH = 4; // Boot-select strap width
    localparam int SYNC_STAGES = 3; // Pin synchroniser depth
    localparam int CLK_PERIOD_NS = 100; // System clock period
    localparam int RELEASE_TIME_NS = 400; // Least hold after sources clear
    localparam int RELEASE_CYCLES = (RELEASE_TIME_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam int CNT_WIDTH = 4; // Release counter width
    // ------------------------------------------------------------
    // Reset values of captured straps
    // ------------------------------------------------------------
    localparam logic [BOOT_WIDTH-1:0] BOOT_RESET = 4'h0;
    localparam logic ENDIAN_RESET = 1'h0;

    // Sequencer states
    typedef enum logic [1:0] {
        ST_HOLD = 2'b00,
        ST_WAIT = 2'b01,
        ST_RUN = 2'b10
    } seq_state_type;

    // Captured strap configuration
    typedef struct packed {
        logic littleEndian;
        logic [BOOT_WIDTH-1:0] bootMode;
    } strap_cfg_type;
endpackage

/* File: verilog/pin_sync.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module pin_sync
    import reset_pkg::*;
#(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] pinIn,
    output logic [WIDTH-1:0] pinOut
);
    // Stage registers; first stage only feeds the second
    logic [WIDTH-1:0] s1_reg;
    logic [WIDTH-1:0] s2_reg;
    logic [WIDTH-1:0] s3_reg;
    logic [WIDTH-1:0] out_reg;
    // Accept a change once stages two and three agree
    wire [WIDTH-1:0] agree = ~(s2_reg ^ s3_reg);
    wire [WIDTH-1:0] out_next = (agree & s3_reg) | (~agree & out_reg);

    // Shift chain
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_reg <= INIT;
            s2_reg <= INIT;
            s3_reg <= INIT;
            out_reg <= INIT;
        end else begin
            s1_reg <= pinIn;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            out_reg <= out_next;
        end
    end
    assign pinOut = out_reg;
endmodule // pin_sync
`default_nettype wire

/* File: verilog/system_reset.sv */
// Reset combiner, module reset distribution and strap capture
// Notes on behaviour
// R1 - Master reset holds all modules except reset/clock
// R2 - Drive active-low reset out from all sources
// R3 - Power-on reset input is active high
// R4 - Sample endian strap at reset; high is little
// R5 - Latch four boot-select straps at reset
// R6 - Release only after all sources clear, synchronised
`timescale 1ns/100ps
`default_nettype none
module system_reset
    import reset_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic powerOnReset,
    input wire logic masterReset_n,
    input wire logic watchdogTimeout,
    input wire logic endianStrap,
    input wire logic [BOOT_WIDTH-1:0] bootStrap,
    output logic systemReset_n,
    output logic moduleReset_n,
    output strap_cfg_type strapCfg
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic porSync; // Power-on level after filtering
    logic mrSync_n; // Master reset after filtering
    logic endianSync; // Endian strap after filtering
    logic [BOOT_WIDTH-1:0] bootSync; // Boot straps after filtering

    // Reset inputs start asserted so nothing runs before they settle
    pin_sync #(.WIDTH(2), .INIT(2'h1)) u_rstSync (
        .clk(sys_clk),
        .rst_n(rst_n),
        .pinIn({masterReset_n, powerOnReset}),
        .pinOut({mrSync_n, porSync})
    );
    pin_sync #(.WIDTH(BOOT_WIDTH + 1), .INIT(5'h00)) u_strapSync (
        .clk(sys_clk),
        .rst_n(rst_n),
        .pinIn({endianStrap, bootStrap}),
        .pinOut({endianSync, bootSync})
    );

    // ------------------------------------------------------------
    // Source combining
    // ------------------------------------------------------------
    wire porActive = porSync; // High level means power-up event [R3]
    wire masterActive = ~mrSync_n; // Low pin level is master reset [R1]
    // Watchdog comes from logic on this clock, so no synchroniser
    wire anySource = porActive | masterActive | watchdogTimeout; // [R2]

    // ------------------------------------------------------------
    // Release sequencer
    // ------------------------------------------------------------
    seq_state_type state_reg;
    seq_state_type state_next;
    logic [CNT_WIDTH-1:0] cnt_reg; // Cycles since sources cleared
    logic [CNT_WIDTH-1:0] cnt_next;
    logic sysRst_reg; // Registered reset out
    logic modRst_reg; // Registered module reset
    strap_cfg_type cfg_reg; // Captured straps
    strap_cfg_type cfg_next;

    wire cntDone = (cnt_reg == CNT_WIDTH'(RELEASE_CYCLES - 1));
    wire inReset = (state_next != ST_RUN);

    // Next state: any source returns to hold at once [R6]
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        unique case (state_reg)
            ST_HOLD: begin
                cnt_next = '0;
                if (!anySource) begin
                    state_next = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (anySource) begin
                    state_next = ST_HOLD; // Source came back [R6]
                    cnt_next = '0;
                end else if (cntDone) begin
                    state_next = ST_RUN;
                end else begin
                    cnt_next = cnt_reg + 1'b1;
                end
            end
            ST_RUN: begin
                if (anySource) begin
                    state_next = ST_HOLD;
                end
            end
            default: begin
                state_next = ST_HOLD; // Illegal code recovers to reset
                cnt_next = '0;
            end
        endcase
    end

    // Straps follow the pins while in reset, freeze at release [R4] [R5]
    always_comb begin
        cfg_next = cfg_reg;
        if (state_reg != ST_RUN) begin
            cfg_next.littleEndian = endianSync; // High means little [R4]
            cfg_next.bootMode = bootSync; // [R5]
        end
    end

    // State and outputs registered
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_HOLD;
            cnt_reg <= '0;
            sysRst_reg <= 1'b0;
            modRst_reg <= 1'b0;
            cfg_reg <= '{littleEndian: ENDIAN_RESET, bootMode: BOOT_RESET};
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            sysRst_reg <= ~inReset; // [R2] [R6]
            modRst_reg <= ~inReset; // [R1]
            cfg_reg <= cfg_next;
        end
    end

    assign systemReset_n = sysRst_reg;
    assign moduleReset_n = modRst_reg;
    assign strapCfg = cfg_reg;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    // Everything here lives on the system clock, so clock and disable
    // are given once; a local reset silences all checks at once
    default clocking assertClk @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    // Master reset must keep the module reset low one edge later
    AST_MASTER_HOLDS: assert property ( // [R1]
        masterActive |=> !moduleReset_n)
        else $error("Module reset not held during master reset");

    // Watchdog is unsynchronised, so it bites within two edges
    AST_WDOG_OUT: assert property ( // [R2]
        watchdogTimeout |=> ##1 !systemReset_n)
        else $error("Watchdog timeout did not assert reset out");

    // High power-on level is a reset request
    AST_POR_HIGH: assert property ( // [R3]
        porActive |=> ##1 !systemReset_n)
        else $error("Power-on level did not assert reset out");

    // Power-on request also reaches the module reset
    AST_POR_MODULES: assert property ( // [R3]
        porActive |=> !moduleReset_n)
        else $error("Power-on level did not reset the modules");

    // Once running, the captured straps must not move
    AST_ENDIAN_FROZEN: assert property ( // [R4]
        (systemReset_n && $past(systemReset_n) && state_reg == ST_RUN)
        |-> $stable(strapCfg))
        else $error("Strap configuration changed outside reset");

    // In reset the endian bit follows the filtered strap
    AST_ENDIAN_TRACK: assert property ( // [R4]
        (state_reg != ST_RUN)
        |=> (strapCfg.littleEndian == $past(endianSync)))
        else $error("Endian strap not tracked during reset");

    // In the hold state the boot mode follows the filtered straps
    AST_BOOT_CAPTURE: assert property ( // [R5]
        (state_reg == ST_HOLD) |=> (strapCfg.bootMode == $past(bootSync)))
        else $error("Boot straps not tracked during reset");

    // Release only follows clean cycles
    AST_RELEASE_DELAY: assert property ( // [R6]
        $rose(systemReset_n) |-> $past(!anySource, 2))
        else $error("Reset released while a source was active");

    // Six clean cycles are enough to see the output released
    AST_RELEASE_BOUND: assert property ( // [R6]
        (!anySource) [*6] |-> systemReset_n)
        else $error("Reset out not released after sources cleared");

    // A source during the count restarts it from hold
    AST_SOURCE_RESTART: assert property ( // [R6]
        (state_reg == ST_WAIT && anySource)
        |=> (state_reg == ST_HOLD && cnt_reg == '0))
        else $error("Returning source did not restart the count");

    // Run state is only entered from a clean cycle
    AST_RUN_CLEAN: assert property ( // [R6]
        (state_reg == ST_RUN) |-> $past(!anySource))
        else $error("Run entered while a source was active");

    // Both outputs come from the same decision
    AST_OUTS_MATCH: assert property ( // [R1]
        systemReset_n == moduleReset_n)
        else $error("Module reset and reset out disagree");

    // ------------------------------------------------------------
    // Cover points for the main scenarios
    // ------------------------------------------------------------
    COV_POR_RELEASE: cover property (
        porActive ##[1:20] $rose(systemReset_n));
    COV_MASTER: cover property (
        $fell(mrSync_n) ##[1:20] $rose(systemReset_n));
    COV_WDOG: cover property (
        systemReset_n ##1 watchdogTimeout ##2 !systemReset_n);
    COV_LITTLE: cover property (
        $rose(systemReset_n) && strapCfg.littleEndian);
    COV_BIG: cover property (
        $rose(systemReset_n) && !strapCfg.littleEndian);
endmodule // system_reset
`default_nettype wire

/* File: test/board_reset_model.sv */
// Board-side model: power-up detector, reset switch and strap pins
`timescale 1ns/100ps
`default_nettype none
module board_reset_model
    import reset_pkg::*;
#(
    parameter int POR_HOLD_NS = 500 // RC settle time, plain default
) (
    input wire logic powerUp,
    input wire logic switchPressed,
    input wire logic endianSel,
    input wire logic [BOOT_WIDTH-1:0] bootSel,
    output logic powerOnReset,
    output logic masterReset_n,
    output logic endianStrap,
    output logic [BOOT_WIDTH-1:0] bootStrap
);
    // RC detector: high from power-off, falls late after power-up
    initial powerOnReset = 1'h1;
    always @(powerUp) begin
        powerOnReset <= #(powerUp ? POR_HOLD_NS : 0) !powerUp;
    end
    // Switch pulls the master reset low while pressed
    assign masterReset_n = !switchPressed;
    // Straps are resistors that follow the select inputs at once
    assign endianStrap = endianSel;
    assign bootStrap = bootSel;
endmodule // board_reset_model
`default_nettype wire

/* File: test/system_reset_and_strap_capture_tb_top.sv */
// Self-checking bench for reset combining and strap capture
`timescale 1ns/100ps
`default_nettype none
module system_reset_and_strap_capture_tb_top
    import reset_pkg::*;
;
    // ------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------
    logic sys_clk, rst_n, watchdogTimeout, powerUp, switchPressed;
    logic endianSel, powerOnReset, masterReset_n, endianStrap;
    logic [BOOT_WIDTH-1:0] bootSel, bootStrap;
    logic systemReset_n, moduleReset_n;
    strap_cfg_type strapCfg;
    int error_cnt, samples_checked, cycleCnt;
    board_reset_model i_board_reset_model (.powerUp(powerUp),
        .switchPressed(switchPressed), .endianSel(endianSel),
        .bootSel(bootSel), .powerOnReset(powerOnReset),
        .masterReset_n(masterReset_n), .endianStrap(endianStrap),
        .bootStrap(bootStrap));
    system_reset i_system_reset (.sys_clk(sys_clk), .rst_n(rst_n),
        .powerOnReset(powerOnReset), .masterReset_n(masterReset_n),
        .watchdogTimeout(watchdogTimeout), .endianStrap(endianStrap),
        .bootStrap(bootStrap), .systemReset_n(systemReset_n),
        .moduleReset_n(moduleReset_n), .strapCfg(strapCfg));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check(input logic ok, input string msg);
        samples_checked++;
        if (ok !== 1'h1) begin
            error_cnt++;
            $display("Error at %0t: %s", $time, msg);
        end
    endtask
    // Inputs always move 10 ns after the rising edge
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #10;
    endtask
    // Both reset outputs must agree at every look
    task automatic outsAre(input logic lvl);
        check(systemReset_n === lvl && moduleReset_n === lvl, "reset outs");
    endtask
    // Bounded wait for release, so a stuck output cannot hang us
    task automatic waitRelease(input int maxCyc);
        int n;
        n = 0;
        while (systemReset_n !== 1'h1 && n < maxCyc) begin
            step(1);
            n++;
        end
        outsAre(1'h1);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic powerOnScenario;
        step(5);
        outsAre(1'h0);
        powerUp = 1'h1;
        step(8);
        outsAre(1'h0);
        waitRelease(14);
        check(strapCfg === {1'h1, 4'hA}, "little endian capture");
    endtask
    // Switch press also moves the straps: capture must follow them
    task automatic masterScenario;
        switchPressed = 1'h1;
        endianSel = 1'h0;
        bootSel = 4'h5;
        step(6);
        outsAre(1'h0);
        switchPressed = 1'h0;
        step(5);
        outsAre(1'h0);
        waitRelease(12);
        check(strapCfg === {1'h0, 4'h5}, "big endian capture");
    endtask
    task automatic watchdogScenario;
        endianSel = 1'h1;
        bootSel = 4'hF;
        watchdogTimeout = 1'h1;
        step(1);
        watchdogTimeout = 1'h0;
        step(2);
        outsAre(1'h0);
        step(2);
        outsAre(1'h0);
        check(strapCfg === {1'h1, 4'hF}, "straps in reset");
        waitRelease(8);
    endtask
    // Straps must be frozen while running; local reset clears all
    task automatic frozenScenario;
        endianSel = 1'h0;
        bootSel = 4'h3;
        step(8);
        check(strapCfg === {1'h1, 4'hF}, "straps frozen");
        rst_n = 1'h0;
        step(1);
        outsAre(1'h0);
        check(strapCfg === '0, "strap clear");
        rst_n = 1'h1;
        step(2);
        outsAre(1'h0);
        waitRelease(14);
        check(strapCfg === {1'h0, 4'h3}, "recapture after reset");
    endtask
    // ------------------------------------------------------------
    // Verdict, timeout and main sequence
    // ------------------------------------------------------------
    task automatic summarize;
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        sys_clk = 1'h0;
        forever #50 sys_clk = ~sys_clk;
    end
    // Whole run needs about 60 cycles; 2000 means a hang
    always @(posedge sys_clk) begin
        cycleCnt++;
        if (cycleCnt == 2000) begin
            error_cnt++;
            summarize();
        end
    end
    initial begin
        {rst_n, watchdogTimeout, powerUp, switchPressed} = 4'h0;
        endianSel = 1'h1;
        bootSel = 4'hA;
        {error_cnt, samples_checked, cycleCnt} = '0;
        step(2);
        rst_n = 1'h1;
        powerOnScenario();
        masterScenario();
        watchdogScenario();
        frozenScenario();
        summarize();
    end
endmodule // system_reset_and_strap_capture_tb_top
`default_nettype wire
